// ===== logic/acss_pkg.sv
package acss_pkg;
  localparam int CLK_HZ      = 20_000_000;
  localparam int RATE_MIN_HZ = 28_000;
  localparam int RATE_MAX_HZ = 200_000;
  localparam int DS_LO_HZ    = 88_200;
  localparam int DS_HI_HZ    = 96_000;
  localparam int DEF_RATE_HZ = 48_000;
  // longest period rounds up, shortest rounds down
  localparam int PER_MAX  = (CLK_HZ + RATE_MIN_HZ - 1) / RATE_MIN_HZ;
  localparam int PER_MIN  = CLK_HZ / RATE_MAX_HZ;
  localparam int DS_PMAX  = (CLK_HZ + DS_LO_HZ - 1) / DS_LO_HZ;
  localparam int DS_PMIN  = CLK_HZ / DS_HI_HZ;
  localparam int PER_W    = 10;
  localparam int NIN      = 3;
  localparam int QUAL_DEF = 4;
  localparam int MATCH_TOL = 4;

  localparam logic [PER_W-1:0] PLAY_RST = PER_W'(CLK_HZ / DEF_RATE_HZ);

  localparam logic [1:0] REF_WC  = 2'h0;
  localparam logic [1:0] REF_OPT = 2'h1;
  localparam logic [1:0] REF_SER = 2'h2;
  localparam logic [1:0] REF_INT = 2'h3;

  localparam logic [1:0] LK_NONE = 2'h0;
  localparam logic [1:0] LK_LOCK = 2'h1;
  localparam logic [1:0] LK_SYNC = 2'h2;

  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_PLAY = 8'h04;
  localparam logic [AW-1:0] OFF_STAT = 8'h08;
  localparam logic [AW-1:0] OFF_WPER = 8'h0c;
  localparam logic [AW-1:0] OFF_OPER = 8'h10;
  localparam logic [AW-1:0] OFF_SPER = 8'h14;
  localparam logic [AW-1:0] OFF_ACT  = 8'h18;
  localparam logic [AW-1:0] OFF_SYS  = 8'h1c;
  localparam logic [AW-1:0] OFF_IRQS = 8'h20;
  localparam logic [AW-1:0] OFF_IRQM = 8'h24;

  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PREF = 1;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam int ST_SLAVE_B = 0;
  localparam int ST_SMUX_B  = 1;
  localparam int ST_SEL_B   = 2;
  localparam int ST_LOCK_B  = 4;

  localparam int IRQ_W      = 5;
  localparam int IRQ_REF    = 0;
  localparam int IRQ_MASTER = 1;
  localparam int IRQ_LOCK   = 2;

  typedef enum logic [1:0] {
    ACSS_ST_MASTER = 2'b01,
    ACSS_ST_SLAVE  = 2'b10
  } acss_state_e;

  typedef struct packed {
    logic             chk;
    logic             ok;
    logic [PER_W-1:0] per;
  } acss_meas_s;
endpackage

// ===== logic/acss_rate_meter.sv
module acss_rate_meter #(
  parameter int PMIN = acss_pkg::PER_MIN,
  parameter int PMAX = acss_pkg::PER_MAX
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                link_i,
  output acss_pkg::acss_meas_s     meas_o
);
  import acss_pkg::*;

  logic             s1_q;
  logic             s2_q;
  logic             s3_q;
  logic [PER_W-1:0] cnt_q;
  logic             rise;
  logic             tmo;
  logic [PER_W-1:0] per;
  logic             arm_q;

  assign rise = s2_q & ~s3_q;
  assign tmo  = (cnt_q == PER_W'(PMAX));
  assign per  = cnt_q + PER_W'(1);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= link_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // first edge after silence only restarts timing: its partial period is no check
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      arm_q <= 1'b0;
    end else if (rise) begin
      arm_q <= 1'b1;
    end else if (tmo) begin
      arm_q <= 1'b0;
    end
  end

  // a missing edge ends the check as invalid, so a dead input decays
  always_ff @(posedge core_clk_i) begin
    if (rst_i || rise || tmo) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + PER_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meas_o <= '0;
    end else begin
      meas_o.chk <= (rise & arm_q) | tmo;
      meas_o.ok  <= rise && arm_q && !tmo && (per >= PER_W'(PMIN));
      if (rise && arm_q && !tmo && (per >= PER_W'(PMIN))) begin
        meas_o.per <= per;
      end
    end
  end

  property p_bounds;
    @(posedge core_clk_i) disable iff (rst_i)
      meas_o.ok |-> (meas_o.per >= PER_W'(PMIN)) && (meas_o.per <= PER_W'(PMAX));
  endproperty
  AST_RATE_BOUNDS: assert property (p_bounds)
    else $error("accepted period outside rate range");

  AST_SCAN_TIMEOUT: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      (cnt_q == PER_W'(PMAX)) |=> meas_o.chk && !meas_o.ok && (cnt_q == '0))
    else $error("silent input not reported as invalid check");
endmodule

// ===== logic/acss_clock_select.sv
// How it works
// - in automatic mode each clock input is timed edge to edge and judged valid or not.
// - a valid input at the playback rate moves the clock off the crystal and flags slave.
// - with automatic mode off the block always runs from its own clock.
// - word clock, optical and serial inputs are all watched at once and only one becomes reference.
// - the preferred input wins whenever valid, else the others are tried in order.
// - with no valid input in automatic mode the block falls back to master by itself.
// - status names the active reference and its measured period.
// - each input reports no lock, lock, or sync with the system clock.
// - any rate from 28 to 200 kHz is accepted on every input.
// - double speed with the optical input preferred turns on sample multiplexing.
// - under multiplexing the optical link is expected and shown at half the rate.
// - only word clock, optical and serial inputs are candidates.
// - system status shows master or slave and the resulting period.
//
// Chosen here: the register addresses and the APB register port.
module acss_clock_select #(
  parameter int QUAL = acss_pkg::QUAL_DEF
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wclk_i,
  input  wire logic                     opt_clk_i,
  input  wire logic                     ser_clk_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [acss_pkg::AW-1:0]  paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  output logic                          irq_o,
  output logic      [1:0]               clk_src_o,
  output logic                          slave_o,
  output logic                          smux_o
);
  import acss_pkg::*;

  localparam int QW = $clog2(QUAL + 1);

  function automatic logic near(input logic [PER_W:0] a, input logic [PER_W:0] b);
    logic [PER_W:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= (PER_W + 1)'(MATCH_TOL);
  endfunction

  acss_meas_s       meas [NIN];
  logic [NIN-1:0]   lnk;
  logic [QW-1:0]    qcnt_q [NIN];
  logic [NIN-1:0]   qual_q;
  logic [NIN-1:0]   match;
  logic [PER_W:0]   expct [NIN];
  logic [1:0]       lock_q [NIN];
  logic [1:0]       lock_d [NIN];
  logic             auto_q;
  logic [1:0]       pref_q;
  logic [PER_W-1:0] ply_q;
  logic             dbl;
  logic [1:0]       cand;
  acss_state_e      state_q;
  acss_state_e      state_d;
  logic [1:0]       sel_d;
  logic [PER_W-1:0] act_per_q;
  logic [PER_W-1:0] sys_per_q;
  logic [IRQ_W-1:0] irqs_q;
  logic [IRQ_W-1:0] irqm_q;
  logic [IRQ_W-1:0] ev;
  logic             acc;
  logic             wr;
  logic [31:0]      rd;
  logic             hit;

  assign lnk = {ser_clk_i, opt_clk_i, wclk_i};

  for (genvar g = 0; g < NIN; g++) begin : g_meter
    acss_rate_meter #(
      .PMIN (PER_MIN),
      .PMAX (PER_MAX)
    ) u_meter (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .link_i     (lnk[g]),
      .meas_o     (meas[g])
    );
  end

  // up on a good check, down on a bad one: brief dropouts do not flip the source
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NIN; i++) begin
      if (rst_i) begin
        qcnt_q[i] <= '0;
        qual_q[i] <= 1'b0;
      end else if (meas[i].chk) begin
        if (meas[i].ok && qcnt_q[i] != QW'(QUAL)) begin
          qcnt_q[i] <= qcnt_q[i] + QW'(1);
          if (qcnt_q[i] == QW'(QUAL - 1)) begin
            qual_q[i] <= 1'b1;
          end
        end else if (!meas[i].ok && qcnt_q[i] != '0) begin
          qcnt_q[i] <= qcnt_q[i] - QW'(1);
          if (qcnt_q[i] == QW'(1)) begin
            qual_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign dbl = (ply_q >= PER_W'(DS_PMIN)) && (ply_q <= PER_W'(DS_PMAX));

  // optical link carries two channels per sample, so it ticks at half rate
  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      expct[i] = {1'b0, ply_q};
      if (i == int'(REF_OPT) && smux_o) begin
        expct[i] = {ply_q, 1'b0};
      end
      match[i] = qual_q[i] && near({1'b0, meas[i].per}, expct[i]);
    end
  end

  always_comb begin
    cand = REF_INT;
    if (pref_q != REF_INT && match[pref_q]) begin
      cand = pref_q;
    end else begin
      for (int i = NIN - 1; i >= 0; i--) begin
        if (match[i]) begin
          cand = 2'(i);
        end
      end
    end
  end

  always_comb begin
    state_d = state_q;
    sel_d   = clk_src_o;
    case (state_q)
      ACSS_ST_MASTER: begin
        if (auto_q && cand != REF_INT) begin
          state_d = ACSS_ST_SLAVE;
          sel_d   = cand;
        end
      end
      ACSS_ST_SLAVE: begin
        if (!auto_q || cand == REF_INT) begin
          state_d = ACSS_ST_MASTER;
          sel_d   = REF_INT;
        end else begin
          sel_d   = cand;
        end
      end
      default: begin
        state_d = ACSS_ST_MASTER;
        sel_d   = REF_INT;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q   <= ACSS_ST_MASTER;
      clk_src_o <= REF_INT;
      slave_o   <= 1'b0;
      smux_o    <= 1'b0;
    end else begin
      state_q   <= state_d;
      clk_src_o <= sel_d;
      slave_o   <= (state_d == ACSS_ST_SLAVE);
      smux_o    <= dbl && (pref_q == REF_OPT);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      act_per_q <= '0;
      sys_per_q <= PLAY_RST;
    end else if (state_d == ACSS_ST_SLAVE) begin
      act_per_q <= meas[sel_d].per;
      sys_per_q <= (sel_d == REF_OPT && smux_o) ? meas[sel_d].per >> 1
                                                : meas[sel_d].per;
    end else begin
      act_per_q <= '0;
      sys_per_q <= ply_q;
    end
  end

  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      if (!qual_q[i]) begin
        lock_d[i] = LK_NONE;
      end else if (slave_o ? (clk_src_o == 2'(i)) : match[i]) begin
        lock_d[i] = LK_SYNC;
      end else begin
        lock_d[i] = LK_LOCK;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NIN; i++) begin
      if (rst_i) begin
        lock_q[i] <= LK_NONE;
      end else begin
        lock_q[i] <= lock_d[i];
      end
    end
  end

  always_comb begin
    ev             = '0;
    ev[IRQ_REF]    = (sel_d != clk_src_o);
    ev[IRQ_MASTER] = (state_q == ACSS_ST_SLAVE) && (state_d == ACSS_ST_MASTER) && auto_q;
    for (int i = 0; i < NIN; i++) begin
      ev[IRQ_LOCK + i] = (lock_d[i] != lock_q[i]);
    end
  end

  // second access cycle carries the write, matching the edge the master sees pready
  assign acc = psel_i & penable_i & ~pready_o;
  assign wr  = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

  always_comb begin
    hit = (paddr_i[1:0] == 2'h0);
    rd  = '0;
    case (paddr_i)
      OFF_CTRL: rd[CTRL_PREF+1:0] = {pref_q, auto_q};
      OFF_PLAY: rd[PER_W-1:0] = ply_q;
      OFF_STAT: rd[ST_LOCK_B+2*NIN-1:0] = {lock_q[2], lock_q[1], lock_q[0],
                                           clk_src_o, smux_o, slave_o};
      OFF_WPER: rd[PER_W-1:0] = meas[REF_WC].per;
      OFF_OPER: rd[PER_W-1:0] = meas[REF_OPT].per;
      OFF_SPER: rd[PER_W-1:0] = meas[REF_SER].per;
      OFF_ACT:  rd[PER_W-1:0] = act_per_q;
      OFF_SYS:  rd[PER_W-1:0] = sys_per_q;
      OFF_IRQS: rd[IRQ_W-1:0] = irqs_q;
      OFF_IRQM: rd[IRQ_W-1:0] = irqm_q;
      default:  hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= acc;
      pslverr_o <= acc & ~hit;
      if (acc) begin
        prdata_o <= pwrite_i ? '0 : rd;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      auto_q <= CTRL_AUTO_RST;
      pref_q <= REF_WC;
      ply_q  <= PLAY_RST;
      irqm_q <= '0;
    end else if (wr) begin
      case (paddr_i)
        OFF_CTRL: begin
          auto_q <= pwdata_i[CTRL_AUTO];
          pref_q <= pwdata_i[CTRL_PREF+1:CTRL_PREF];
        end
        OFF_PLAY: ply_q  <= pwdata_i[PER_W-1:0];
        OFF_IRQM: irqm_q <= pwdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // a new event in the clearing cycle survives
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irqs_q <= '0;
      irq_o  <= 1'b0;
    end else begin
      irqs_q <= (irqs_q & ~((wr && paddr_i == OFF_IRQS) ? pwdata_i[IRQ_W-1:0] : '0)) | ev;
      irq_o  <= |(irqs_q & irqm_q);
    end
  end

  AST_MANUAL_MASTER: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      !auto_q |=> !slave_o && (clk_src_o == REF_INT))
    else $error("manual master left internal clock");

  AST_FALLBACK: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      (auto_q && match == '0) |=> !slave_o && (clk_src_o == REF_INT))
    else $error("no valid input but not master");

  AST_PREF_WINS: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      (auto_q && pref_q != REF_INT && match[pref_q]) |=> slave_o && (clk_src_o == $past(pref_q)))
    else $error("preferred valid input not chosen");

  AST_SLAVE_CAUSE: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(slave_o) |-> $past(auto_q) && $past(match[cand]) && (clk_src_o == $past(cand)))
    else $error("slave without a rate matched input");

  AST_SMUX: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      ##1 smux_o == ($past(pref_q) == REF_OPT && $past(dbl)))
    else $error("multiplex mode wrong");

  AST_OPT_HALF: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      (smux_o && slave_o && clk_src_o == REF_OPT) ##1 (slave_o && clk_src_o == REF_OPT)
        |-> sys_per_q == (act_per_q >> 1))
    else $error("optical rate not halved under multiplex");

  AST_QUALIFY: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(qual_q[0]) |-> $past(qcnt_q[0]) == QW'(QUAL - 1) && $past(meas[0].ok))
    else $error("input qualified too early");

  AST_LOCK_NONE: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      !qual_q[1] |=> lock_q[1] == LK_NONE)
    else $error("unqualified input shows lock");

  AST_ACT_PER: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      slave_o && $stable(clk_src_o) |-> act_per_q == $past(meas[clk_src_o].per))
    else $error("active period not of selected input");

  AST_REF_RANGE: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      slave_o |-> clk_src_o != REF_INT)
    else $error("slave on non candidate source");

  AST_SYS_MASTER: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
      !slave_o ##1 !slave_o |-> sys_per_q == $past(ply_q))
    else $error("master period not playback period");
endmodule

// ===== tb/acss_src_model.sv
module acss_src_model (
  input  wire logic [2:0]      en_i,
  input  wire logic [2:0][9:0] per_i,
  output logic      [2:0]      lnk_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // period in core cycles; the odd start offset keeps pin edges off the core clock edges
  // a source switched off holds its line low, like an unplugged input
  for (genvar k = 0; k < 3; k++) begin : g_src
    initial begin
      lnk_o[k] = 1'b0;
      #7;
      forever begin
        if (en_i[k]) begin
          #(per_i[k] * 25);
          lnk_o[k] = ~lnk_o[k];
        end else begin
          lnk_o[k] = 1'b0;
          #50;
        end
      end
    end
  end
endmodule

// ===== tb/test_audio_clock_source_select.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module test_audio_clock_source_select;
  timeunit 1ns;
  timeprecision 1ns;
  import acss_pkg::*;

  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0;
  logic            pen = 1'b0;
  logic            pwr = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready, pslverr, irq, slave, smux, last_err;
  logic [1:0]      src;
  logic [2:0]      en = 3'h0;
  logic [2:0][9:0] per = {3{10'h1a0}};
  logic [2:0]      lnk;
  int              miscompares = 0;
  int              checks = 0;

  always #25 clk = ~clk;

  acss_clock_select #(.QUAL(QUAL_DEF)) u_acss_clock_select (
    .core_clk_i(clk), .rst_i(rst), .wclk_i(lnk[0]), .opt_clk_i(lnk[1]),
    .ser_clk_i(lnk[2]), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .clk_src_o(src), .slave_o(slave), .smux_o(smux));

  acss_src_model u_acss_src_model (.en_i(en), .per_i(per), .lnk_o(lnk));

  task automatic conclude();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d);
  endtask

  // qualification needs several input periods, so waits are generous but bounded
  task automatic wait_src(input logic [1:0] e);
    int n;
    n = 0;
    while (src !== e && n < 8000) begin
      @(posedge clk);
      n++;
    end
    if (src !== e) begin
      miscompares++;
      conclude();
    end
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] ctrl(input logic auto, input logic [1:0] pref);
    return 32'({pref, auto});
  endfunction

  function automatic logic [1:0] lk(input logic [31:0] s, input int k);
    return s[ST_LOCK_B + 2 * k +: 2];
  endfunction

  initial begin
    #(100_000 * 50);
    miscompares++;
    conclude();
  end

  initial begin
    logic [31:0] d, d2;
    int unsigned j;
    int          bad;
    j = $urandom(39);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(src, REF_INT)
    rd(OFF_CTRL, d);
    `CHK(d, ctrl(CTRL_AUTO_RST, REF_WC))
    rd(OFF_PLAY, d);
    `CHK(d, 32'(PLAY_RST))
    rd(8'h28, d);
    `CHK(last_err, 1'b1)
    `CHK(d, 32'h0)
    wait_src(REF_INT);
    `CHK(slave, 1'b0)
    wr(OFF_IRQS, 32'h1f);
    wr(OFF_IRQM, 32'(1 << IRQ_REF));
    // word clock with a small random offset, serial fed the too-fast 400 ns clock
    j = $urandom_range(0, 3);
    per[0] <= 10'(PLAY_RST + j);
    per[2] <= 10'd8;
    en     <= 3'b101;
    wait_src(REF_WC);
    `CHK(src, REF_WC)
    `CHK(slave, 1'b1)
    `CHK(irq, 1'b1)
    rd(OFF_STAT, d);
    `CHK(lk(d, 0), LK_SYNC)
    `CHK(lk(d, 2), LK_NONE)
    `CHK(d[ST_SEL_B +: 2], REF_WC)
    rd(OFF_ACT, d);
    `CHK(d, 32'(PLAY_RST + j))
    wr(OFF_IRQS, 32'(1 << IRQ_REF));
    rd(OFF_IRQS, d);
    `CHK(d[IRQ_REF], 1'b0)
    `CHK(irq, 1'b0)
    wr(OFF_IRQM, 32'h0);
    // brief dropout must not move the reference
    bad = 0;
    en[0] <= 1'b0;
    repeat (800) begin
      @(posedge clk);
      if (src !== REF_WC) bad++;
    end
    en[0] <= 1'b1;
    `CHK(bad, 0)
    per[1] <= PLAY_RST;
    per[2] <= PLAY_RST;
    en     <= 3'b111;
    repeat (3000) @(posedge clk);
    wr(OFF_CTRL, ctrl(1'b1, REF_SER));
    wait_src(REF_SER);
    `CHK(src, REF_SER)
    rd(OFF_STAT, d);
    `CHK(lk(d, 0), LK_LOCK)
    `CHK(lk(d, 2), LK_SYNC)
    wr(OFF_CTRL, ctrl(1'b1, REF_INT));
    wait_src(REF_WC);
    `CHK(src, REF_WC)
    en[0] <= 1'b0;
    wait_src(REF_OPT);
    `CHK(src, REF_OPT)
    wr(OFF_CTRL, ctrl(1'b0, REF_INT));
    wait_src(REF_INT);
    `CHK(src, REF_INT)
    `CHK(slave, 1'b0)
    rd(OFF_SYS, d);
    `CHK(d, 32'(PLAY_RST))
    wr(OFF_CTRL, ctrl(1'b1, REF_INT));
    wait_src(REF_OPT);
    wr(OFF_IRQS, 32'h1f);
    wr(OFF_IRQM, 32'(1 << IRQ_MASTER));
    en <= 3'b000;
    wait_src(REF_INT);
    `CHK(src, REF_INT)
    `CHK(irq, 1'b1)
    rd(OFF_IRQS, d);
    `CHK(d[IRQ_MASTER], 1'b1)
    wr(OFF_IRQM, 32'h0);
    // both ends of the accepted rate range on the word clock
    foreach (per[k]) begin
      if (k < 2) begin
        d2 = (k == 0) ? 32'd100 : 32'd714;
        wr(OFF_PLAY, d2);
        per[0] <= d2[9:0];
        en[0]  <= 1'b1;
        wait_src(REF_WC);
        `CHK(src, REF_WC)
        en[0] <= 1'b0;
        wait_src(REF_INT);
      end
    end
    wr(OFF_PLAY, 32'd208);
    wr(OFF_CTRL, ctrl(1'b1, REF_OPT));
    per[1] <= 10'd416;
    per[2] <= 10'd208;
    en     <= 3'b110;
    wait_src(REF_OPT);
    `CHK(src, REF_OPT)
    `CHK(smux, 1'b1)
    rd(OFF_OPER, d);
    rd(OFF_SPER, d2);
    `CHK(d, 32'd416)
    `CHK(d2, 32'd208)
    conclude();
  end
endmodule
